// *** tb/drive_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module drive_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        jogRun,
  input  wire logic        jogDir,
  input  wire logic        posRun,
  input  wire logic [31:0] posTarget,
  input  wire logic        hardStop,
  input  wire logic [2:0]  swSel,
  input  wire logic [31:0] swPos,
  input  wire logic        swNeg,
  input  wire logic        swLow,
  input  wire logic [31:0] idxPos,
  output var  logic [31:0] actualPosition,
  output var  logic        motionIdle,
  output var  logic [2:0]  digitalIn,
  output var  logic        indexPulse
);
  logic [1:0] coast;
  logic       lastDir;
  logic       swOn;
  // Switch closes beyond swPos in its own direction; low-active wiring inverts it
  assign swOn = swNeg ? ($signed(actualPosition) <= $signed(swPos))
                      : ($signed(actualPosition) >= $signed(swPos));
  assign digitalIn = swSel & {3{swOn ^ swLow}};
  assign indexPulse = actualPosition >= idxPos && actualPosition <= idxPos + 32'h7;
  assign motionIdle = !jogRun && coast == 2'h0 && (!posRun || actualPosition == posTarget);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      actualPosition <= 32'h0;
      coast <= 2'h0;
      lastDir <= 1'b0;
    end else if (hardStop) begin
      coast <= 2'h0;
    end else if (jogRun) begin
      actualPosition <= jogDir ? actualPosition + 32'h1 : actualPosition - 32'h1;
      lastDir <= jogDir;
      coast <= 2'h3;
    end else if (coast != 2'h0) begin
      // Ramped stop overshoots a few counts
      actualPosition <= lastDir ? actualPosition + 32'h1 : actualPosition - 32'h1;
      coast <= coast - 2'h1;
    end else if (posRun && actualPosition != posTarget) begin
      actualPosition <= ($signed(posTarget) > $signed(actualPosition)) ?
                        actualPosition + 32'h1 : actualPosition - 32'h1;
    end
  end
endmodule : drive_model
`default_nettype wire

// *** tb/homing_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"
module homing_assertions (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        abortIn,
  input wire logic        homingExit,
  input wire logic        jogRun,
  input wire logic        posRun,
  input wire logic [31:0] posTarget,
  input wire logic [15:0] speed,
  input wire logic        hardStop,
  input wire logic        positionLoop,
  input wire logic        axisHoming,
  input wire logic [31:0] refPosition
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_hard_stop;
    hardStop |-> !jogRun && !posRun;
  endproperty
  a_hard_stop: assert property (p_hard_stop) else $error("move during hard stop");
  property p_one_move;
    !(jogRun && posRun);
  endproperty
  a_one_move: assert property (p_one_move) else $error("jog and return together");
  property p_speed_window;
    jogRun || posRun |-> speed >= `HM_VEL_MIN && speed <= `HM_VEL_MAX;
  endproperty
  a_speed_window: assert property (p_speed_window) else $error("speed outside window");
  property p_return_held;
    posRun && $past(posRun) |-> $stable(posTarget) && $stable(speed);
  endproperty
  a_return_held: assert property (p_return_held) else $error("return target moved");
  property p_loop_sticky;
    positionLoop |=> positionLoop;
  endproperty
  a_loop_sticky: assert property (p_loop_sticky) else $error("position loop dropped");
  property p_jog_homing;
    jogRun |-> axisHoming && positionLoop;
  endproperty
  a_jog_homing: assert property (p_jog_homing) else $error("search without homing");
  property p_exit;
    homingExit && !jogRun && !posRun |=> !axisHoming;
  endproperty
  a_exit: assert property (p_exit) else $error("homing kept after exit");
  property p_abort;
    abortIn |=> !jogRun && !posRun;
  endproperty
  a_abort: assert property (p_abort) else $error("motion after abort");
  property p_ref_load;
    !$stable(refPosition) |-> $past(posRun);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("reference changed early");
endmodule : homing_assertions

bind homing_switch_and_index_search homing_assertions chk_i (
  .clk(clk), .resetn(resetn), .abortIn(abortIn), .homingExit(homingExit),
  .jogRun(jogRun), .posRun(posRun), .posTarget(posTarget), .speed(speed),
  .hardStop(hardStop), .positionLoop(positionLoop), .axisHoming(axisHoming),
  .refPosition(refPosition));
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"
module tb_top;
  typedef struct {
    logic [15:0] vel; logic [11:0] fn; logic [3:0] src;
    logic [2:0] cond; logic [4:0] ctrl; logic [15:0] code;
  } row_t;
  row_t rows [9];
  logic clk, resetn, read, write, waitrequest, indexPulse, driveDisabled, driveStopping;
  logic otherMotion, abortIn, homingExit, motionIdle, jogRun, jogDir, posRun, hardStop;
  logic positionLoop, axisHoming, swNeg, swLow;
  logic [7:0] address;
  logic [2:0] digitalIn, swSel;
  logic [15:0] speed;
  logic [31:0] writedata, readdata, actualPosition, posTarget, refPosition, q, swPos, idxPos;
  int fails = 0;
  int n_checks = 0;

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  homing_switch_and_index_search uut (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .digitalIn(digitalIn), .indexPulse(indexPulse), .driveDisabled(driveDisabled),
    .driveStopping(driveStopping), .otherMotion(otherMotion), .abortIn(abortIn),
    .homingExit(homingExit), .actualPosition(actualPosition), .motionIdle(motionIdle),
    .jogRun(jogRun), .jogDir(jogDir), .posRun(posRun), .posTarget(posTarget),
    .speed(speed), .hardStop(hardStop), .positionLoop(positionLoop),
    .axisHoming(axisHoming), .refPosition(refPosition));
  drive_model partner (
    .clk(clk), .resetn(resetn), .jogRun(jogRun), .jogDir(jogDir), .posRun(posRun),
    .posTarget(posTarget), .hardStop(hardStop), .swSel(swSel), .swPos(swPos),
    .swNeg(swNeg), .swLow(swLow), .idxPos(idxPos), .actualPosition(actualPosition),
    .motionIdle(motionIdle), .digitalIn(digitalIn), .indexPulse(indexPulse));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) begin
      fails++;
      stop_test();
    end
    @(posedge clk);
  endtask : bus

  task automatic start(input logic [4:0] ctrl);
    bus(1'b1, `HM_ADDR_CTRL, 32'h0);
    bus(1'b1, `HM_ADDR_CTRL, {27'h0, ctrl});
    bus(1'b0, `HM_ADDR_STATUS, 32'h0);
  endtask : start

  // Waits for done, then releases execute; leaves the captured position in q
  task automatic finish(input int b, input logic [31:0] lo);
    int n;
    n = 0;
    do begin
      bus(1'b0, `HM_ADDR_STATUS, 32'h0);
      n++;
    end while (q[b] !== 1'b1 && n < 300);
    if (n >= 300) begin
      fails++;
      stop_test();
    end
    chk(q[b-1 -: 2], 2'b00, "busy active at done");
    bus(1'b1, `HM_ADDR_CTRL, 32'h0);
    bus(1'b0, `HM_ADDR_STATUS, 32'h0);
    chk(q[b], 1'b0, "done after release");
    bus(1'b0, `HM_ADDR_CAPPOS, 32'h0);
    chk(actualPosition, q, "back at capture");
    chk(posTarget, q, "return target");
    chk({posRun, hardStop}, 2'b00, "return ended");
    chk(q >= lo && q <= lo + 32'h7, 1'b1, "capture at edge");
  endtask : finish

  initial begin
    {resetn, read, write, driveDisabled, driveStopping, otherMotion} = '0;
    {abortIn, homingExit, swNeg, swLow} = '0;
    address = 8'h0;
    writedata = 32'h0;
    swSel = 3'b010;
    swPos = 32'h28;
    idxPos = 32'h3C;
    rows = '{
      '{16'h0, 12'hCC0, 4'h4, 3'b000, 5'h05, 16'h003C},
      '{16'hBB9, 12'hCC0, 4'h4, 3'b000, 5'h05, 16'h003D},
      '{16'h5, 12'hCC0, 4'h4, 3'b100, 5'h05, 16'h0043},
      '{16'h5, 12'hCC0, 4'h4, 3'b010, 5'h05, 16'h0045},
      '{16'h5, 12'hCC0, 4'h0, 3'b000, 5'h05, 16'h0047},
      '{16'h5, 12'hCC0, 4'h4, 3'b001, 5'h05, 16'h004C},
      '{16'h5, 12'hEEE, 4'h4, 3'b000, 5'h05, 16'h004D},
      '{16'h5, 12'hDDD, 4'h4, 3'b000, 5'h01, 16'h004D},
      '{16'h0, 12'hCC0, 4'h4, 3'b000, 5'h02, 16'h3C4D}};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    bus(1'b0, `HM_ADDR_VEL, 32'h0);
    chk(q, 32'h64, "velocity reset");
    bus(1'b1, `HM_ADDR_STATUS, 32'hFFFF);
    bus(1'b0, `HM_ADDR_STATUS, 32'h0);
    chk(q, 32'h0, "status read only");
    bus(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped read");
    foreach (rows[i]) begin
      {driveDisabled, driveStopping, otherMotion} <= rows[i].cond;
      bus(1'b1, `HM_ADDR_VEL, {16'h0, rows[i].vel});
      bus(1'b1, `HM_ADDR_DIFUNC, {20'h0, rows[i].fn});
      bus(1'b1, `HM_ADDR_SOURCE, {28'h0, rows[i].src});
      start(rows[i].ctrl);
      chk(q[15:0], rows[i].ctrl[1] ? 16'h1000 : 16'h0010, "refused flags");
      chk(jogRun, 1'b0, "no motion");
      bus(1'b0, `HM_ADDR_CODES, 32'h0);
      chk(q[15:0], rows[i].code, "error code");
    end
    {driveDisabled, driveStopping, otherMotion} <= 3'b000;
    bus(1'b1, `HM_ADDR_VEL, 32'h5);
    start(5'h05);
    chk({q[1:0], jogDir}, 3'b111, "limit search start");
    finish(2, 32'h28);
    chk(speed, 16'h5, "speed");
    chk(refPosition, 32'h0000_0000, "reference kept by limit step");
    chk({positionLoop, axisHoming}, 2'b11, "after limit step");
    start(5'h05);
    chk(jogDir, 1'b0, "leave active switch");
    finish(2, 32'h28);
    {swSel, swPos, swNeg, swLow} <= {3'b001, 32'h14, 2'b11};
    bus(1'b1, `HM_ADDR_DIFUNC, 32'hCCF);
    start(5'h09);
    chk({jogRun, jogDir}, 2'b10, "negative falling search");
    finish(2, 32'hD);
    bus(1'b1, `HM_ADDR_PRESET, 32'h000A_2000);
    start(5'h12);
    chk({q[9:8], jogDir}, 3'b111, "index search start");
    finish(10, 32'h3C);
    chk(refPosition, 32'h000A_2000, "reference loaded");
    chk({positionLoop, axisHoming}, 2'b10, "after index");
    start(5'h05);
    chk({jogRun, axisHoming}, 2'b11, "running again");
    abortIn <= 1'b1;
    @(posedge clk);
    abortIn <= 1'b0;
    bus(1'b0, `HM_ADDR_STATUS, 32'h0);
    chk(q[3:0], 4'h8, "abort drops busy and pulses aborted");
    chk(jogRun, 1'b0, "abort stops jog");
    bus(1'b0, `HM_ADDR_STATUS, 32'h0);
    chk(q[3], 1'b0, "aborted lasts one cycle");
    homingExit <= 1'b1;
    @(posedge clk);
    homingExit <= 1'b0;
    @(posedge clk);
    chk(axisHoming, 1'b0, "homing exit");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire

// *** verilog/homing_defs.svh ***
`ifndef HOMING_DEFS_SVH
`define HOMING_DEFS_SVH

// Register byte addresses
`define HM_ADDR_CTRL     8'h00
`define HM_ADDR_VEL      8'h04
`define HM_ADDR_PRESET   8'h08
`define HM_ADDR_DIFUNC   8'h0C
`define HM_ADDR_SOURCE   8'h10
`define HM_ADDR_STATUS   8'h14
`define HM_ADDR_CODES    8'h18
`define HM_ADDR_REFPOS   8'h1C
`define HM_ADDR_CAPPOS   8'h20

// Control register fields
`define HM_CTRL_EXEC_LIMIT   0
`define HM_CTRL_EXEC_INDEX   1
`define HM_CTRL_LIMIT_POS    2
`define HM_CTRL_EDGE_FALL    3
`define HM_CTRL_INDEX_POS    4

// Status register field bases: one group per step, then the homing and position loop flags and the state
`define HM_ST_LIMIT      0
`define HM_ST_INDEX      8
`define HM_ST_HOMING     16
`define HM_ST_POSLOOP    17
`define HM_ST_STATE      18

// Digital input function codes for a limit switch
`define HM_FN_POS_RISE   4'hC
`define HM_FN_POS_FALL   4'hD
`define HM_FN_NEG_RISE   4'hE
`define HM_FN_NEG_FALL   4'hF

// Step error codes (decimal values 60 61 67 69 71 76 77)
`define HM_ERR_NONE      8'h00
`define HM_ERR_SLOW      8'h3C
`define HM_ERR_FAST      8'h3D
`define HM_ERR_DISABLED  8'h43
`define HM_ERR_STOPPING  8'h45
`define HM_ERR_SOURCE    8'h47
`define HM_ERR_STATE     8'h4C
`define HM_ERR_NOSWITCH  8'h4D

`define HM_SOURCE_PROGRAM 4'h4

// Permitted speed window
`define HM_VEL_MIN       16'h0001
`define HM_VEL_MAX       16'h0BB8

// Reset values
`define HM_RST_VEL       16'h0064
`define HM_RST_DIFUNC    12'h000
`define HM_RST_SOURCE    4'h0
`define HM_RST_WORD      32'h0000_0000

`endif

// *** verilog/homing_pkg.sv ***
package homing_pkg;

  typedef enum logic [2:0] {
    IDLE       = 3'h0,
    LEAVE      = 3'h1,
    LEAVE_STOP = 3'h3,
    SEEK       = 3'h2,
    HIT_STOP   = 3'h6,
    RETURN     = 3'h7
  } state_t;

endpackage : homing_pkg

// *** verilog/homing_switch_and_index_search.sv ***
// Chosen here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "homing_defs.svh"

module homing_switch_and_index_search
  import homing_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  input  wire logic [2:0]  digitalIn,
  input  wire logic        indexPulse,
  input  wire logic        driveDisabled,
  input  wire logic        driveStopping,
  input  wire logic        otherMotion,
  input  wire logic        abortIn,
  input  wire logic        homingExit,
  input  wire logic [31:0] actualPosition,
  input  wire logic        motionIdle,
  output var  logic        jogRun,
  output var  logic        jogDir,
  output var  logic        posRun,
  output var  logic [31:0] posTarget,
  output var  logic [15:0] speed,
  output var  logic        hardStop,
  output var  logic        positionLoop,
  output var  logic        axisHoming,
  output var  logic [31:0] refPosition
);

  // Software-written configuration
  logic        execLimit;
  logic        execIndex;
  logic        limitDirPos;
  logic        edgeFalling;
  logic        indexDirPos;
  logic [15:0] velocity;
  logic [31:0] presetPos;
  logic [11:0] diFunc;
  logic [3:0]  ctrlSource;

  // Execute edge detection
  logic        prevExecLimit;
  logic        prevExecIndex;
  logic        startLimit;
  logic        startIndex;

  // Per-step status, index 0 limit search, index 1 index search
  logic [1:0]  busy;
  logic [1:0]  done;
  logic [1:0]  aborted;
  logic [1:0]  errFlag;
  logic [7:0]  errCode [2];
  logic [1:0]  execVec;

  // Captured arguments of the running step
  logic        runStep;
  logic        runDirPos;
  logic        runEdgeFalling;
  logic [1:0]  runSel;
  logic [31:0] runPreset;
  logic [31:0] capturePos;
  state_t      state;

  // Synchronised pins
  logic [2:0]  diLevel;
  logic        indexLevel;
  logic        prevIndex;
  logic        prevSelActive;
  logic        selActive;
  logic        selEdge;
  logic        indexEdge;

  // Start qualification
  logic [3:0]  wantCode;
  logic        found;
  logic [1:0]  foundSel;
  logic [7:0]  commonCode;
  logic [7:0]  codeLimit;
  logic [7:0]  codeIndex;
  logic        acceptLimit;
  logic        acceptIndex;
  logic        refuseLimit;
  logic        refuseIndex;
  logic        accept;
  logic        newStep;
  logic        abortNow;
  logic        finish;
  logic        startActive;
  logic        wrEn;
  logic [31:0] rdMux;

  pin_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk    (clk),
    .resetn (resetn),
    .pinIn  ({indexPulse, digitalIn}),
    .level  ({indexLevel, diLevel})
  );

  assign execVec    = {execIndex, execLimit};
  assign startLimit = execLimit & ~prevExecLimit;
  assign startIndex = execIndex & ~prevExecIndex;

  always_comb begin
    if (limitDirPos) begin
      wantCode = edgeFalling ? `HM_FN_POS_FALL : `HM_FN_POS_RISE;
    end else begin
      wantCode = edgeFalling ? `HM_FN_NEG_FALL : `HM_FN_NEG_RISE;
    end
    found    = 1'b0;
    foundSel = 2'b00;
    // Scan downwards so the lowest matching input wins
    for (int i = 2; i >= 0; i--) begin
      if (diFunc[i*4 +: 4] == wantCode) begin
        found    = 1'b1;
        foundSel = 2'(i);
      end
    end
  end

  always_comb begin
    if (velocity < `HM_VEL_MIN) begin
      commonCode = `HM_ERR_SLOW;
    end else if (velocity > `HM_VEL_MAX) begin
      commonCode = `HM_ERR_FAST;
    end else if (driveDisabled) begin
      commonCode = `HM_ERR_DISABLED;
    end else if (driveStopping) begin
      commonCode = `HM_ERR_STOPPING;
    end else if (ctrlSource != `HM_SOURCE_PROGRAM) begin
      commonCode = `HM_ERR_SOURCE;
    end else if (otherMotion) begin
      commonCode = `HM_ERR_STATE;
    end else begin
      commonCode = `HM_ERR_NONE;
    end
    codeIndex = commonCode;
    if (commonCode == `HM_ERR_NONE && !found) begin
      codeLimit = `HM_ERR_NOSWITCH;
    end else begin
      codeLimit = commonCode;
    end
  end

  // A limit edge in the same cycle as an index edge takes precedence
  assign acceptLimit = startLimit & (codeLimit == `HM_ERR_NONE);
  assign refuseLimit = startLimit & (codeLimit != `HM_ERR_NONE);
  assign acceptIndex = startIndex & ~startLimit & (codeIndex == `HM_ERR_NONE);
  assign refuseIndex = startIndex & ~startLimit & (codeIndex != `HM_ERR_NONE);
  assign accept      = acceptLimit | acceptIndex;
  assign newStep     = ~acceptLimit;
  assign abortNow    = busy[runStep] & (abortIn | accept);

  assign startActive = diLevel[foundSel] ^ edgeFalling;
  assign selActive   = diLevel[runSel] ^ runEdgeFalling;
  assign selEdge     = selActive & ~prevSelActive;
  assign indexEdge   = indexLevel & ~prevIndex;
  assign finish      = (state == RETURN) & motionIdle & (actualPosition == capturePos);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevExecLimit <= 1'b0;
      prevExecIndex <= 1'b0;
      prevIndex     <= 1'b0;
    end else begin
      prevExecLimit <= execLimit;
      prevExecIndex <= execIndex;
      prevIndex     <= indexLevel;
    end
  end

  // Search sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state          <= IDLE;
      runStep        <= 1'b0;
      runDirPos      <= 1'b0;
      runEdgeFalling <= 1'b0;
      runSel         <= 2'b00;
      runPreset      <= `HM_RST_WORD;
      capturePos     <= `HM_RST_WORD;
      prevSelActive  <= 1'b0;
      jogRun         <= 1'b0;
      jogDir         <= 1'b0;
      posRun         <= 1'b0;
      posTarget      <= `HM_RST_WORD;
      speed          <= `HM_RST_VEL;
      hardStop       <= 1'b0;
    end else if (accept) begin
      runStep        <= newStep;
      runDirPos      <= newStep ? indexDirPos : limitDirPos;
      runEdgeFalling <= edgeFalling;
      runSel         <= foundSel;
      runPreset      <= presetPos;
      speed          <= velocity;
      posRun         <= 1'b0;
      hardStop       <= 1'b0;
      jogRun         <= 1'b1;
      prevSelActive  <= startActive;
      if (!newStep && startActive) begin
        jogDir <= ~limitDirPos;
        state  <= LEAVE;
      end else begin
        jogDir <= newStep ? indexDirPos : limitDirPos;
        state  <= SEEK;
      end
    end else if (abortIn) begin
      state    <= IDLE;
      jogRun   <= 1'b0;
      posRun   <= 1'b0;
      hardStop <= 1'b0;
    end else begin
      prevSelActive <= selActive;
      unique case (state)
        IDLE: begin
        end
        LEAVE: begin
          if (!selActive) begin
            jogRun <= 1'b0;
            state  <= LEAVE_STOP;
          end
        end
        LEAVE_STOP: begin
          if (motionIdle) begin
            jogRun <= 1'b1;
            jogDir <= runDirPos;
            state  <= SEEK;
          end
        end
        SEEK: begin
          if (runStep ? indexEdge : selEdge) begin
            capturePos <= actualPosition;
            jogRun     <= 1'b0;
            hardStop   <= ~runStep;
            state      <= HIT_STOP;
          end
        end
        HIT_STOP: begin
          if (motionIdle) begin
            hardStop  <= 1'b0;
            posRun    <= 1'b1;
            posTarget <= capturePos;
            state     <= RETURN;
          end
        end
        RETURN: begin
          if (finish) begin
            posRun <= 1'b0;
            state  <= IDLE;
          end
        end
      endcase
    end
  end

  // Per-step handshake outputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      busy       <= 2'b00;
      done       <= 2'b00;
      aborted    <= 2'b00;
      errFlag    <= 2'b00;
      errCode[0] <= `HM_ERR_NONE;
      errCode[1] <= `HM_ERR_NONE;
    end else begin
      for (int s = 0; s < 2; s++) begin
        aborted[s] <= abortNow & (runStep == 1'(s));
        if (accept && newStep == 1'(s)) begin
          busy[s]    <= 1'b1;
          done[s]    <= 1'b0;
          errFlag[s] <= 1'b0;
          errCode[s] <= `HM_ERR_NONE;
        end else begin
          if ((finish || abortNow) && runStep == 1'(s)) begin
            busy[s] <= 1'b0;
          end
          if (finish && runStep == 1'(s)) begin
            done[s] <= 1'b1;
          end else begin
            done[s] <= done[s] & execVec[s];
          end
          errFlag[s] <= errFlag[s] & execVec[s];
        end
      end
      if (refuseLimit) begin
        errFlag[0] <= 1'b1;
        errCode[0] <= codeLimit;
        done[0]    <= 1'b0;
      end
      if (refuseIndex) begin
        errFlag[1] <= 1'b1;
        errCode[1] <= codeIndex;
        done[1]    <= 1'b0;
      end
    end
  end

  // Axis state, loop mode and reference position
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      positionLoop <= 1'b0;
      axisHoming   <= 1'b0;
      refPosition  <= `HM_RST_WORD;
    end else begin
      if (accept) begin
        positionLoop <= 1'b1;
        axisHoming   <= 1'b1;
      end else if (finish && runStep) begin
        axisHoming   <= 1'b0;
      end else if (homingExit) begin
        axisHoming   <= 1'b0;
      end
      if (!accept && finish && runStep) begin
        refPosition <= runPreset;
      end
    end
  end

  // Avalon-MM slave: one wait cycle, then a single answer cycle
  assign wrEn = write & ~waitrequest;

  always_comb begin
    rdMux = `HM_RST_WORD;
    unique case (address)
      `HM_ADDR_CTRL: begin
        rdMux[`HM_CTRL_EXEC_LIMIT] = execLimit;
        rdMux[`HM_CTRL_EXEC_INDEX] = execIndex;
        rdMux[`HM_CTRL_LIMIT_POS]  = limitDirPos;
        rdMux[`HM_CTRL_EDGE_FALL]  = edgeFalling;
        rdMux[`HM_CTRL_INDEX_POS]  = indexDirPos;
      end
      `HM_ADDR_VEL:    rdMux[15:0] = velocity;
      `HM_ADDR_PRESET: rdMux = presetPos;
      `HM_ADDR_DIFUNC: rdMux[11:0] = diFunc;
      `HM_ADDR_SOURCE: rdMux[3:0] = ctrlSource;
      `HM_ADDR_STATUS: begin
        rdMux[`HM_ST_LIMIT +: 5] = {errFlag[0], aborted[0], done[0], busy[0], busy[0]};
        rdMux[`HM_ST_INDEX +: 5] = {errFlag[1], aborted[1], done[1], busy[1], busy[1]};
        rdMux[`HM_ST_HOMING]     = axisHoming;
        rdMux[`HM_ST_POSLOOP]    = positionLoop;
        rdMux[`HM_ST_STATE +: 3] = state;
      end
      `HM_ADDR_CODES:  rdMux[15:0] = {errCode[1], errCode[0]};
      `HM_ADDR_REFPOS: rdMux = refPosition;
      `HM_ADDR_CAPPOS: rdMux = capturePos;
      default:         rdMux = `HM_RST_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      waitrequest <= 1'b1;
      readdata    <= `HM_RST_WORD;
    end else if (waitrequest && (read || write)) begin
      waitrequest <= 1'b0;
      readdata    <= rdMux;
    end else begin
      waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      execLimit   <= 1'b0;
      execIndex   <= 1'b0;
      limitDirPos <= 1'b0;
      edgeFalling <= 1'b0;
      indexDirPos <= 1'b0;
      velocity    <= `HM_RST_VEL;
      presetPos   <= `HM_RST_WORD;
      diFunc      <= `HM_RST_DIFUNC;
      ctrlSource  <= `HM_RST_SOURCE;
    end else if (wrEn) begin
      unique case (address)
        `HM_ADDR_CTRL: begin
          execLimit   <= writedata[`HM_CTRL_EXEC_LIMIT];
          execIndex   <= writedata[`HM_CTRL_EXEC_INDEX];
          limitDirPos <= writedata[`HM_CTRL_LIMIT_POS];
          edgeFalling <= writedata[`HM_CTRL_EDGE_FALL];
          indexDirPos <= writedata[`HM_CTRL_INDEX_POS];
        end
        `HM_ADDR_VEL:    velocity   <= writedata[15:0];
        `HM_ADDR_PRESET: presetPos  <= writedata;
        `HM_ADDR_DIFUNC: diFunc     <= writedata[11:0];
        `HM_ADDR_SOURCE: ctrlSource <= writedata[3:0];
        default: begin
        end
      endcase
    end
  end

endmodule : homing_switch_and_index_search

`default_nettype wire

// *** verilog/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] level
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      level  <= '0;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
      // Accept a new level only once the last two stages agree
      level  <= (agree & stage3) | (~agree & level);
    end
  end

endmodule : pin_sync

`default_nettype wire
